// File: tlad_datapath.sv
// Datapath executing status loads and operand loads with optional product accumulation.
// What this block does
// [RL1] Load-status-n copies the data word into status register n.
// [RL2] Second-status load writes the data word into the second status register.
// [RL3] Operand load fills the operand register; accumulator and product untouched.
// [RL4] Load-operand-accumulate loads operand and adds previous product to accumulator.
// [RL5] Product is shifted by the product shift mode field before any add.
// [RL6] Load-accumulate-move loads operand and adds product to accumulator.
// [RL7] Load-accumulate-move also writes the data word to the next higher address.
// [RL8] Software uses the data move only inside on-chip data RAM.
// [RL9] Load-operand-store-product loads operand and puts product into accumulator.
// [RL10] Direct address is page pointer joined with the seven-bit offset field.
// [RL11] Accumulate uses the product held before the instruction began.
`timescale 1ns/1ps
`default_nettype none
module tlad_datapath #(
  parameter int DATA_W = tlad_pkg::DATA_W,
  parameter int ACC_W  = tlad_pkg::ACC_W
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        op_valid,
  input  wire logic [2:0]                  op_code,
  input  wire logic                        status_index,
  input  wire logic                        indirect,
  input  wire logic [tlad_pkg::OFS_W-1:0]  dma_offset,
  input  wire logic [tlad_pkg::ADDR_W-1:0] indirect_addr,
  input  wire logic [tlad_pkg::PAGE_W-1:0] page_pointer,
  input  wire logic [ACC_W-1:0]            product_in,
  input  wire logic [DATA_W-1:0]           mem_rdata,
  output logic                             busy,
  output logic                             mem_rd,
  output logic                             mem_wr,
  output logic      [tlad_pkg::ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0]           mem_wdata,
  output logic      [DATA_W-1:0]           status0,
  output logic      [DATA_W-1:0]           second_status_register,
  output logic      [DATA_W-1:0]           multiplier_operand_register,
  output logic      [ACC_W-1:0]            accumulator,
  output logic                             done
);
  initial begin
    if (DATA_W != tlad_pkg::DATA_W) $error("tlad_datapath: DATA_W must be 16");
    if (ACC_W != tlad_pkg::ACC_W) $error("tlad_datapath: ACC_W must be 32");
  end

  typedef enum {ST_IDLE, ST_READ, ST_EXEC} tlad_state_t;

  typedef struct packed {
    tlad_state_t                  state;
    tlad_pkg::tlad_op_t           op;
    logic                         idx;
    logic [ACC_W-1:0]             prod;
    logic                         busy;
    logic                         rd;
    logic                         wr;
    logic [tlad_pkg::ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]            wdata;
    logic [DATA_W-1:0]            st0;
    logic [DATA_W-1:0]            st1;
    logic [DATA_W-1:0]            treg;
    logic [ACC_W-1:0]             acc;
    logic                         done;
  } tlad_regs_t;

  tlad_regs_t       r_q;
  tlad_regs_t       r_d;
  logic [ACC_W-1:0] scaled;

  // Scaling mode comes from the second status register, as loaded.
  tlad_shifter #(.ACC_W(ACC_W)) u_shift (
    .product (r_q.prod),
    .mode    (r_q.st1[tlad_pkg::PM_LSB +: tlad_pkg::PM_W]),
    .scaled  (scaled)
  ); // [RL5]

  always_comb begin
    r_d      = r_q;
    r_d.wr   = 1'b0;
    r_d.rd   = 1'b0;
    r_d.done = 1'b0;
    case (r_q.state)
      ST_IDLE: begin
        // Codes six and seven, and any request while busy, are dropped without a sign.
        if (op_valid && (op_code < 3'd6)) begin
          r_d.op    = tlad_pkg::tlad_op_t'(op_code);
          r_d.idx   = status_index;
          // Product is captured at issue so a later multiply cannot leak in.
          r_d.prod  = product_in; // [RL11]
          r_d.addr  = indirect ? indirect_addr : {page_pointer, dma_offset}; // [RL10]
          r_d.rd    = 1'b1;
          r_d.busy  = 1'b1;
          r_d.state = ST_READ;
        end
      end
      ST_READ: begin
        r_d.state = ST_EXEC;
      end
      ST_EXEC: begin
        r_d.busy  = 1'b0;
        r_d.done  = 1'b1;
        r_d.state = ST_IDLE;
        case (r_q.op)
          tlad_pkg::OP_LOAD_STATUS: begin
            if (r_q.idx) begin
              r_d.st1 = mem_rdata; // [RL1]
            end else begin
              r_d.st0 = mem_rdata; // [RL1]
            end
          end
          tlad_pkg::OP_LOAD_SECOND_STATUS: begin
            r_d.st1 = mem_rdata; // [RL2]
          end
          tlad_pkg::OP_LOAD_OPERAND: begin
            r_d.treg = mem_rdata; // [RL3]
          end
          tlad_pkg::OP_LOAD_OPERAND_ACCUMULATE: begin
            r_d.treg = mem_rdata; // [RL4]
            r_d.acc  = r_q.acc + scaled; // [RL4] [RL5]
          end
          tlad_pkg::OP_LOAD_ACCUMULATE_MOVE: begin
            r_d.treg  = mem_rdata; // [RL6]
            r_d.acc   = r_q.acc + scaled; // [RL6] [RL5]
            // Address wraps at the top; outside on-chip RAM the move is undefined.
            r_d.addr  = r_q.addr + 16'h0001; // [RL7] [RL8]
            r_d.wdata = mem_rdata; // [RL7]
            r_d.wr    = 1'b1; // [RL7]
          end
          tlad_pkg::OP_LOAD_OPERAND_STORE_PRODUCT: begin
            r_d.treg = mem_rdata; // [RL9]
            // A plain store takes the product as held; only the adding paths scale it.
            r_d.acc  = r_q.prod; // [RL9] [RL11]
          end
          default: begin
            r_d.busy = 1'b0;
          end
        endcase
      end
      default: begin
        r_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_q.state <= ST_IDLE;
      r_q.op    <= tlad_pkg::OP_NONE;
      r_q.idx   <= 1'b0;
      r_q.prod  <= tlad_pkg::ACC_RST;
      r_q.busy  <= 1'b0;
      r_q.rd    <= 1'b0;
      r_q.wr    <= 1'b0;
      r_q.addr  <= tlad_pkg::ADDR_RST;
      r_q.wdata <= tlad_pkg::STATUS_RST;
      r_q.st0   <= tlad_pkg::STATUS_RST;
      r_q.st1   <= tlad_pkg::STATUS_RST;
      r_q.treg  <= tlad_pkg::OPERAND_RST;
      r_q.acc   <= tlad_pkg::ACC_RST;
      r_q.done  <= 1'b0;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign busy                        = r_q.busy;
  assign mem_rd                      = r_q.rd;
  assign mem_wr                      = r_q.wr;
  assign mem_addr                    = r_q.addr;
  assign mem_wdata                   = r_q.wdata;
  assign status0                     = r_q.st0;
  assign second_status_register      = r_q.st1;
  assign multiplier_operand_register = r_q.treg;
  assign accumulator                 = r_q.acc;
  assign done                        = r_q.done;

  // The done checks look back one edge, so they run only when that edge was enabled;
  // a pulse frozen by a low enable is then never held against stale history.
  wire dn = r_q.done;

  status_load_a: assert property (@(posedge mclk) disable iff (rst) // [RL1]
    $past(ce) && dn && $past(r_q.op, 1) == tlad_pkg::OP_LOAD_STATUS && $past(r_q.idx, 1)
    |-> r_q.st1 == $past(mem_rdata, 1)) else $error("status n load wrong");
  status0_load_a: assert property (@(posedge mclk) disable iff (rst) // [RL1]
    $past(ce) && dn && $past(r_q.op, 1) == tlad_pkg::OP_LOAD_STATUS && !$past(r_q.idx, 1)
    |-> r_q.st0 == $past(mem_rdata, 1)) else $error("status zero load wrong");
  second_status_a: assert property (@(posedge mclk) disable iff (rst) // [RL2]
    $past(ce) && dn && $past(r_q.op, 1) == tlad_pkg::OP_LOAD_SECOND_STATUS
    |-> r_q.st1 == $past(mem_rdata, 1)) else $error("second status load wrong");
  operand_only_a: assert property (@(posedge mclk) disable iff (rst) // [RL3]
    $past(ce) && dn && $past(r_q.op, 1) == tlad_pkg::OP_LOAD_OPERAND
    |-> r_q.treg == $past(mem_rdata, 1) && $stable(r_q.acc))
    else $error("operand load disturbed accumulator");
  accumulate_sum_a: assert property (@(posedge mclk) disable iff (rst) // [RL4]
    $past(ce) && dn && $past(r_q.op, 1) == tlad_pkg::OP_LOAD_OPERAND_ACCUMULATE
    |-> r_q.acc == $past(r_q.acc, 1) + $past(scaled, 1)) else $error("accumulate wrong");
  shift_mode_a: assert property (@(posedge mclk) disable iff (rst) // [RL5]
    r_q.st1[1:0] == 2'b01 |-> scaled == {r_q.prod[ACC_W-2:0], 1'b0})
    else $error("product shift wrong");
  move_accum_a: assert property (@(posedge mclk) disable iff (rst) // [RL6]
    $past(ce) && dn && $past(r_q.op, 1) == tlad_pkg::OP_LOAD_ACCUMULATE_MOVE
    |-> r_q.acc == $past(r_q.acc, 1) + $past(scaled, 1)) else $error("move accumulate wrong");
  move_write_a: assert property (@(posedge mclk) disable iff (rst) // [RL7]
    $past(ce) && dn && $past(r_q.op, 1) == tlad_pkg::OP_LOAD_ACCUMULATE_MOVE
    |-> r_q.wr && r_q.addr == $past(r_q.addr, 1) + 16'h0001 && r_q.wdata == $past(mem_rdata, 1))
    else $error("data move wrong");
  store_product_a: assert property (@(posedge mclk) disable iff (rst) // [RL9]
    $past(ce) && dn && $past(r_q.op, 1) == tlad_pkg::OP_LOAD_OPERAND_STORE_PRODUCT
    |-> r_q.acc == $past(r_q.prod, 1)) else $error("store product wrong");
  direct_addr_a: assert property (@(posedge mclk) disable iff (rst) // [RL10]
    ce && r_q.state == ST_IDLE && op_valid && op_code < 3'd6 && !indirect
    |=> r_q.addr == {$past(page_pointer), $past(dma_offset)}) else $error("direct address wrong");
  held_product_a: assert property (@(posedge mclk) disable iff (rst) // [RL11]
    ce && r_q.state == ST_READ |=> ce |-> $stable(r_q.prod)) else $error("product changed mid op");

  cov_accum_c: cover property (@(posedge mclk) dn && r_q.op == tlad_pkg::OP_LOAD_OPERAND_ACCUMULATE);
  cov_move_c:  cover property (@(posedge mclk) r_q.wr);
  cov_store_c: cover property (@(posedge mclk) dn && r_q.op == tlad_pkg::OP_LOAD_OPERAND_STORE_PRODUCT);
  cov_status_c: cover property (@(posedge mclk) dn && r_q.op == tlad_pkg::OP_LOAD_STATUS);
  cov_stall_c: cover property (@(posedge mclk) r_q.state == ST_READ && !ce);
endmodule
`default_nettype wire

// File: tlad_datapath_tb.sv
// Self-checking testbench for the operand-load and accumulate datapath.
`timescale 1ns/1ps
`default_nettype none
module tlad_datapath_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        op_valid = 1'b0;
  logic [2:0]  op_code = 3'h0;
  logic        sidx = 1'b0;
  logic        ind = 1'b0;
  logic [6:0]  ofs = 7'h00;
  logic [15:0] iaddr = 16'h0000;
  logic [8:0]  pp = 9'h000;
  logic [31:0] prod = 32'h0000_0000;
  logic [15:0] rdata = 16'h0000;
  logic        busy, mem_rd, mem_wr, done;
  logic [15:0] maddr, wdata, st0, st1, opr;
  logic [31:0] acc;
  logic [15:0] e_st0, e_st1, e_opr;
  logic [31:0] e_acc;
  int          fail_count = 0;
  int          checked = 0;

  always #25 mclk = ~mclk;

  tlad_datapath u_dut (.mclk(mclk), .rst(rst), .ce(ce), .op_valid(op_valid), .op_code(op_code),
    .status_index(sidx), .indirect(ind), .dma_offset(ofs), .indirect_addr(iaddr),
    .page_pointer(pp), .product_in(prod), .mem_rdata(rdata), .busy(busy), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(maddr), .mem_wdata(wdata), .status0(st0),
    .second_status_register(st1), .multiplier_operand_register(opr), .accumulator(acc),
    .done(done));

  function automatic logic [31:0] scale(input logic [31:0] p, input logic [1:0] pm);
    case (pm)
      2'h1: return p << 1;
      2'h2: return p << 4;
      2'h3: return $signed(p) >>> 6;
      default: return p;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // The hog flag keeps a second request up while busy; it must be ignored.
  task automatic run_op(input logic [2:0] op, input logic [15:0] data, input int stall,
                        input logic hog);
    logic [15:0] a;
    logic [31:0] p;
    logic [31:0] raw;
    logic        take;
    take = op < 3'h6;
    op_valid = 1'b1;
    op_code = op;
    sidx = 1'($urandom);
    ind = 1'($urandom);
    ofs = 7'($urandom);
    iaddr = 16'($urandom);
    pp = 9'($urandom);
    // Moves keep off the top of memory, where no next higher RAM word exists.
    if (op == 3'h4) begin
      pp[8] = 1'b0;
      iaddr[15] = 1'b0;
    end
    prod = $urandom;
    raw = prod;
    a = ind ? iaddr : {pp, ofs};
    p = scale(prod, e_st1[1:0]);
    @(posedge mclk);
    #1;
    // A refused code held high stays refused; a taken one is shadowed by busy.
    op_valid = hog;
    op_code = take ? 3'h2 : op;
    prod = ~prod;
    rdata = data;
    chk_flag(mem_rd, take, "mem_rd");
    chk_flag(busy, take, "busy");
    if (take) chk_word(maddr, a, "address");
    ce = (stall == 0);
    repeat (stall) @(posedge mclk);
    #1;
    ce = 1'b1;
    @(posedge mclk);
    #1;
    op_valid = 1'b0;
    @(posedge mclk);
    #1;
    rdata = ~data;
    chk_flag(done, take, "done");
    chk_flag(busy, 1'b0, "busy after done");
    chk_flag(mem_wr, op == 3'h4, "mem_wr");
    if (op == 3'h4) begin
      chk_word(maddr, 16'(a + 16'h0001), "move address");
      chk_word(wdata, data, "move data");
    end
    case (op)
      3'h0: if (sidx) e_st1 = data; else e_st0 = data;
      3'h1: e_st1 = data;
      3'h2: e_opr = data;
      3'h3, 3'h4: begin
        e_opr = data;
        e_acc = e_acc + p;
      end
      3'h5: begin
        e_opr = data;
        e_acc = raw;
      end
      default: ;
    endcase
    chk_word(st0, e_st0, "status0");
    chk_word(st1, e_st1, "second status");
    chk_word(opr, e_opr, "operand");
    chk(acc, e_acc, "accumulator");
  endtask

  initial begin
    #(2_000_000);
    fail_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    void'($urandom(94));
    e_st0 = 16'h0000;
    e_st1 = 16'h0000;
    e_opr = 16'h0000;
    e_acc = 32'h0000_0000;
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk_word({12'h000, busy, done, mem_rd, mem_wr}, 16'h0000, "flags after reset");
    chk(acc, e_acc, "accumulator after reset");
    // Each product-using operation runs under every shift mode; only the adding ones are scaled by it.
    for (int pm = 0; pm < 4; pm++) begin
      run_op(3'h1, {14'h0000, 2'(pm)}, 0, 1'b0);
      for (int op = 3; op < 6; op++) run_op(3'(op), 16'($urandom), 0, 1'b0);
    end
    for (int op = 0; op < 8; op++) run_op(3'(op), 16'($urandom), 0, 1'b1);
    run_op(3'h4, 16'hffff, 3, 1'b1);
    run_op(3'h3, 16'h8000, 2, 1'b0);
    for (int i = 0; i < 80; i++) run_op(3'($urandom), 16'($urandom), 0, 1'($urandom));
    summarize();
  end
endmodule
`default_nettype wire

// File: tlad_pkg.sv
// Package of shared constants and types for the operand-load and accumulate datapath.
package tlad_pkg;
  localparam int DATA_W     = 16;
  localparam int ACC_W      = 32;
  localparam int PAGE_W     = 9;
  localparam int OFS_W      = 7;
  localparam int ADDR_W     = 16;
  localparam int NUM_STATUS = 2;
  localparam int PM_W       = 2;
  localparam int PM_LSB     = 0;
  localparam logic [DATA_W-1:0] STATUS_RST = 16'h0000;
  localparam logic [DATA_W-1:0] OPERAND_RST = 16'h0000;
  localparam logic [ACC_W-1:0]  ACC_RST     = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST    = 16'h0000;
  localparam int RD_LATENCY = 1;

  typedef enum logic [2:0] {
    OP_LOAD_STATUS,
    OP_LOAD_SECOND_STATUS,
    OP_LOAD_OPERAND,
    OP_LOAD_OPERAND_ACCUMULATE,
    OP_LOAD_ACCUMULATE_MOVE,
    OP_LOAD_OPERAND_STORE_PRODUCT,
    OP_NONE
  } tlad_op_t;

  // Product shift modes: none, left 1, left 4, right 6 arithmetic.
  typedef enum logic [1:0] {
    PM_NONE  = 2'b00,
    PM_LEFT1 = 2'b01,
    PM_LEFT4 = 2'b10,
    PM_RIGHT6 = 2'b11
  } tlad_pm_t;
endpackage

// File: tlad_shifter.sv
// Product scaler that applies the product shift mode before accumulation.
`timescale 1ns/1ps
`default_nettype none
module tlad_shifter #(
  parameter int ACC_W = 32
) (
  input  wire logic [ACC_W-1:0] product,
  input  wire logic [1:0]       mode,
  output logic      [ACC_W-1:0] scaled
);
  initial begin
    if (ACC_W < 8) $error("tlad_shifter: ACC_W too small");
  end

  always_comb begin
    case (mode)
      2'b00:   scaled = product;
      2'b01:   scaled = {product[ACC_W-2:0], 1'b0};
      2'b10:   scaled = {product[ACC_W-5:0], 4'h0};
      default: scaled = {{6{product[ACC_W-1]}}, product[ACC_W-1:6]};
    endcase
  end
endmodule
`default_nettype wire
